/* File: src/port_access_strobe_logic.sv */
////////////////////////////////////////////////////////////////////////////////
// How it works
// - strobe pulses on third_io_port access only while port_strobe_enable is set
// - each port strobe stays low exactly two cpu clock cycles
// - write strobe goes low two cycles after port update, for two cycles
// - read returns pin state latched three cycles before read strobe
// - read strobe starts three cycles after the cpu read, lasts two
// - read strobe samples nothing; it only tells logic to fetch next byte
// - auto_pointer_one address driven only while a strobe is active
// - auto_pointer_two address held whole cycle, length follows stretch
// - stretch lengthens data memory accesses only, never program fetches
// - interface_clock never above 48 MHz
module port_access_strobe_logic
  import port_strobe_pkg::*;
#(
  parameter int INTF_CLOCK_HZ = 48000000
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic port_strobe_enable,
  input wire logic port_wr,
  input wire logic [PORT_W-1:0] port_wr_data,
  input wire logic [PORT_W-1:0] port_dir,
  input wire logic port_rd,
  output logic [PORT_W-1:0] port_rd_data,
  input wire logic [PORT_W-1:0] port_pin_in,
  output logic [PORT_W-1:0] port_pin_out,
  output logic [PORT_W-1:0] port_pin_oe,
  input wire xmem_req_t xmem_req,
  input wire logic [STRETCH_W-1:0] stretch,
  output logic xmem_ready,
  output logic [ADDR_W-1:0] addr_bus,
  output logic addr_oe,
  output strobe_pins_t strobes
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and filter
  logic [PORT_W-1:0] pin_s1_r;
  logic [PORT_W-1:0] pin_s2_r;
  logic [PORT_W-1:0] pin_s3_r;
  logic [PORT_W-1:0] pin_val_r;

  // three stages, value moves once stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else begin
      pin_s1_r <= port_pin_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // per-bit agreement filter
  for (genvar i = 0; i < PORT_W; i++) begin : g_filter
    always_ff @(posedge clock) begin
      if (!rst_b) begin
        pin_val_r[i] <= 1'b0;
      end else if (pin_s2_r[i] == pin_s3_r[i]) begin
        pin_val_r[i] <= pin_s3_r[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port output and read latch
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      port_pin_out <= PORT_OUT_RST;
      port_pin_oe <= '0;
    end else begin
      port_pin_oe <= port_dir;
      if (port_wr) begin
        port_pin_out <= port_wr_data;
      end
    end
  end

  // latch at read
  // the byte is caught at the read itself, three cycles ahead of the strobe
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      port_rd_data <= '0;
    end else if (port_rd) begin
      port_rd_data <= pin_val_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port strobe timing shifters
  logic [WR_SHIFT_LEN-2:0] wr_sh_r;
  logic [RD_SHIFT_LEN-2:0] rd_sh_r;
  logic port_wr_low_r;
  logic port_rd_low_r;

  // gate by enable
  // bit 0 marks the cycle the port output updates or the byte is latched
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_sh_r <= '0;
      rd_sh_r <= '0;
    end else begin
      wr_sh_r <= {wr_sh_r[WR_SHIFT_LEN-3:0], port_wr & port_strobe_enable};
      rd_sh_r <= {rd_sh_r[RD_SHIFT_LEN-3:0], port_rd & port_strobe_enable};
    end
  end

  // no sampling on strobe
  // registered low windows of STROBE_CYCLES after the lead
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      port_wr_low_r <= 1'b0;
      port_rd_low_r <= 1'b0;
    end else begin
      port_wr_low_r <= |wr_sh_r[WR_SHIFT_LEN-2:WR_LEAD_CYCLES-1];
      port_rd_low_r <= |rd_sh_r[RD_SHIFT_LEN-2:RD_LEAD_CYCLES-1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // external data memory cycle
  xmem_state_t xm_state_r;
  xmem_state_t xm_state_nxt;
  xmem_req_t xm_req_r;
  logic [STRETCH_W-1:0] xm_cnt_r;
  logic [STRETCH_W-1:0] xm_len_r;

  assign xmem_ready = (xm_state_r == XM_IDLE);

  // next state
  always_comb begin
    xm_state_nxt = xm_state_r;
    unique case (xm_state_r)
      XM_IDLE: begin
        if (xmem_req.valid) begin
          xm_state_nxt = XM_SETUP;
        end
      end
      XM_SETUP: xm_state_nxt = XM_STROBE;
      XM_STROBE: begin
        if (xm_cnt_r == xm_len_r) begin
          xm_state_nxt = XM_HOLD;
        end
      end
      XM_HOLD: xm_state_nxt = XM_IDLE;
    endcase
  end

  // stretch for data only
  // program fetches always run the shortest strobe
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      xm_state_r <= XM_IDLE;
      xm_req_r <= '0;
      xm_len_r <= '0;
      xm_cnt_r <= '0;
    end else begin
      xm_state_r <= xm_state_nxt;
      if (xmem_ready && xmem_req.valid) begin
        xm_req_r <= xmem_req;
        xm_len_r <= xmem_req.prog_fetch ? '0 : stretch;
      end
      if (xm_state_r == XM_STROBE) begin
        xm_cnt_r <= xm_cnt_r + 1'b1;
      end else begin
        xm_cnt_r <= '0;
      end
    end
  end

  logic xm_strobe;
  assign xm_strobe = (xm_state_r == XM_STROBE);

  always_comb begin
    addr_bus = xm_req_r.addr;
    addr_oe = 1'b0;
    if (xm_state_r != XM_IDLE) begin
      addr_oe = xm_req_r.ptr_two ? 1'b1 : xm_strobe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // strobe pins
  // active low, idle high
  always_comb begin
    strobes.rd_b = ~(port_rd_low_r | (xm_strobe & ~xm_req_r.write));
    strobes.wr_b = ~(port_wr_low_r | (xm_strobe & xm_req_r.write));
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_interface_clock_ceiling:
    assert property (@(posedge clock) INTF_CLOCK_HZ <= INTF_CLOCK_MAX_HZ)
    else $error("interface clock above ceiling");

  a_wr_strobe_lead:
    assert property (@(posedge clock) disable iff (!rst_b)
      (port_wr && port_strobe_enable && xmem_ready && !xmem_req.valid)
      |-> ##3 !strobes.wr_b ##1 !strobes.wr_b)
    else $error("write strobe not low cycles three and four");

  a_rd_strobe_lead:
    assert property (@(posedge clock) disable iff (!rst_b)
      (port_rd && port_strobe_enable && xmem_ready && !xmem_req.valid)
      |-> ##1 strobes.rd_b[*3] ##1 !strobes.rd_b ##1 !strobes.rd_b)
    else $error("read strobe not low cycles four and five");

  a_strobe_width:
    assert property (@(posedge clock) disable iff (!rst_b)
      $rose(port_wr_low_r) |=> port_wr_low_r ##1 (!port_wr_low_r || $past(wr_sh_r[0], 2)))
    else $error("write strobe width wrong");

  a_rd_strobe_width:
    assert property (@(posedge clock) disable iff (!rst_b)
      $rose(port_rd_low_r) |=> port_rd_low_r ##1 (!port_rd_low_r || $past(rd_sh_r[0], 3)))
    else $error("read strobe width wrong");

  a_disabled_quiet:
    assert property (@(posedge clock) disable iff (!rst_b)
      (!port_strobe_enable)[*6] |-> !port_wr_low_r && !port_rd_low_r)
    else $error("port strobe while disabled");

  a_rd_data_held:
    assert property (@(posedge clock) disable iff (!rst_b)
      port_rd |=> port_rd_data == $past(pin_val_r))
    else $error("read data not latched at read");

  a_ptr_one_addr:
    assert property (@(posedge clock) disable iff (!rst_b)
      (addr_oe && !xm_req_r.ptr_two) |-> (!strobes.rd_b || !strobes.wr_b))
    else $error("pointer one address outside strobe");

  a_ptr_two_addr:
    assert property (@(posedge clock) disable iff (!rst_b)
      (xm_state_r == XM_SETUP && xm_req_r.ptr_two) |-> addr_oe[*2])
    else $error("pointer two address dropped");

  a_prog_no_stretch:
    assert property (@(posedge clock) disable iff (!rst_b)
      (xm_state_r == XM_SETUP && xm_req_r.prog_fetch) |=> xm_strobe ##1 (xm_state_r == XM_HOLD))
    else $error("program fetch stretched");

  a_idle_high:
    assert property (@(posedge clock) disable iff (!rst_b)
      (xmem_ready && !port_wr_low_r && !port_rd_low_r) |-> strobes.rd_b && strobes.wr_b)
    else $error("strobe low with no access");

endmodule : port_access_strobe_logic

/* File: shared/port_strobe_pkg.sv */
package port_strobe_pkg;
  // port width
  localparam int PORT_W = 8;
  localparam int ADDR_W = 16;
  localparam int STRETCH_W = 3;
  // cpu clock output period in ns, strobe timing in cpu clock cycles
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int STROBE_CYCLES = 2;
  localparam int WR_LEAD_CYCLES = 2;
  localparam int RD_LEAD_CYCLES = 3;
  // shift lengths derived from the lead and width figures
  localparam int WR_SHIFT_LEN = WR_LEAD_CYCLES + STROBE_CYCLES;
  localparam int RD_SHIFT_LEN = RD_LEAD_CYCLES + STROBE_CYCLES;
  // interface clock ceiling
  localparam int INTF_CLOCK_MAX_HZ = 48000000;
  // reset values
  localparam logic [7:0] PORT_OUT_RST = 8'h00;
  localparam logic STROBE_IDLE = 1'b1;

  // external data memory request
  typedef struct packed {
    logic valid;
    logic write;
    logic ptr_two;
    logic prog_fetch;
    logic [ADDR_W-1:0] addr;
  } xmem_req_t;

  // active-low strobe pins
  typedef struct packed {
    logic rd_b;
    logic wr_b;
  } strobe_pins_t;

  typedef enum logic [1:0] {
    XM_IDLE = 2'b00,
    XM_SETUP = 2'b01,
    XM_STROBE = 2'b10,
    XM_HOLD = 2'b11
  } xmem_state_t;
endpackage : port_strobe_pkg

/* File: sim/port_peripheral_model.sv */
////////////////////////////////////////////////////////////////////////////////
module port_peripheral_model
  import port_strobe_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic rd_b,
  output logic [PORT_W-1:0] pin_val
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_b_r;
  // next byte offered once the read strobe rises
  // change after strobe
  always_ff @(posedge clock) begin
    rd_b_r <= rd_b;
    if (!rst_b) begin
      pin_val <= 8'h5A;
    end else if (rd_b && !rd_b_r) begin
      pin_val <= pin_val + 8'h11;
    end
  end
endmodule : port_peripheral_model

/* File: sim/test_port_access_strobe_logic.sv */
////////////////////////////////////////////////////////////////////////////////
module test_port_access_strobe_logic;
  import port_strobe_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic en; logic rd; logic [7:0] d;} row_t;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic port_strobe_enable = 1'b0;
  logic port_wr = 1'b0;
  logic port_rd = 1'b0;
  logic [7:0] port_wr_data = 8'h00;
  logic [7:0] port_dir = 8'h00;
  logic [7:0] port_rd_data, port_pin_out, port_pin_oe, pins, periph_val;
  xmem_req_t xmem_req = '0;
  logic [2:0] stretch = 3'h0;
  logic xmem_ready, addr_oe;
  logic [15:0] addr_bus;
  strobe_pins_t strobes;
  int bad_count = 0;
  int n_compared = 0;
  logic [7:0] exp_pin = 8'h5A;
  row_t rows[6] = '{'{1, 0, 8'hA5}, '{0, 0, 8'h3C}, '{1, 1, 0}, '{0, 1, 0}, '{1, 1, 0}, '{1, 0, 8'hFF}};
  // wire level from both drivers
  assign pins = (port_pin_oe & port_pin_out) | (~port_pin_oe & periph_val);
  port_access_strobe_logic dut_u (.clock(clock), .rst_b(rst_b), .port_strobe_enable(port_strobe_enable),
    .port_wr(port_wr), .port_wr_data(port_wr_data), .port_dir(port_dir), .port_rd(port_rd),
    .port_rd_data(port_rd_data), .port_pin_in(pins), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .xmem_req(xmem_req), .stretch(stretch), .xmem_ready(xmem_ready), .addr_bus(addr_bus),
    .addr_oe(addr_oe), .strobes(strobes));
  port_peripheral_model periph_u (.clock(clock), .rst_b(rst_b), .rd_b(strobes.rd_b), .pin_val(periph_val));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic rst_chk();
    rst_b <= 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk("idle", {strobes, addr_oe, xmem_ready}, 4'hD);
    chk("port", {port_pin_out, port_pin_oe}, 16'h0000);
  endtask : rst_chk
  task automatic port_op(input row_t r);
    int lead;
    lead = r.rd ? 3 : 2;
    port_strobe_enable <= r.en;
    port_rd <= r.rd;
    port_wr <= !r.rd;
    port_wr_data <= r.d;
    @(posedge clock);
    port_rd <= 1'b0;
    port_wr <= 1'b0;
    for (int k = 1; k <= 6; k++) begin
      #1;
      chk("data", r.rd ? port_rd_data : port_pin_out, r.rd ? exp_pin : r.d);
      chk("stb", r.rd ? strobes.rd_b : strobes.wr_b, !(r.en && k > lead && k <= lead + 2));
      chk("other", r.rd ? strobes.wr_b : strobes.rd_b, 1'b1);
      @(posedge clock);
    end
    if (r.rd && r.en) exp_pin += 8'h11;
    repeat (6) @(posedge clock);
  endtask : port_op
  task automatic xm(input logic wr, input logic p2, input logic prog, input logic [2:0] st, input logic [15:0] a);
    int l;
    logic lo;
    l = prog ? 0 : st;
    xmem_req <= '{1'b1, wr, p2, prog, a};
    stretch <= st;
    @(posedge clock);
    xmem_req <= '0;
    for (int k = 1; k <= l + 4; k++) begin
      #1;
      lo = k >= 2 && k <= l + 2;
      chk("xstb", strobes, {!(lo && !wr), !(lo && wr)});
      chk("aoe", addr_oe, p2 ? k <= l + 3 : lo);
      chk("rdy", xmem_ready, k == l + 4);
      if (k == l + 4) chk("addr", addr_bus, a);
      @(posedge clock);
    end
  endtask : xm
  ////////////////////////////////////////////////////////////////////////////////
  // clock source
  initial forever #20 clock = ~clock;
  // watchdog
  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    finish_test();
  end
  // main sequence
  initial begin
    rst_chk();
    repeat (6) @(posedge clock);
    foreach (rows[i]) port_op(rows[i]);
    xm(1'b0, 1'b1, 1'b0, 3'h2, 16'h1234);
    xm(1'b1, 1'b0, 1'b0, 3'h1, 16'hBEEF);
    xm(1'b0, 1'b1, 1'b1, 3'h7, 16'h00FF);
    xm(1'b1, 1'b1, 1'b0, 3'h0, 16'hFFFF);
    port_dir <= 8'hF0;
    repeat (2) @(posedge clock);
    #1;
    chk("oe", port_pin_oe, 8'hF0);
    rst_chk();
    finish_test();
  end
endmodule : test_port_access_strobe_logic
